// file: logic/twoc_consts.svh
/*
  constants of the timer waveform output control block:
  register offsets, field positions, reset values, counter limits.
  assumes: included by bare name, after nothing in particular.
*/
`ifndef TWOC_CONSTS_SVH
`define TWOC_CONSTS_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define TWOC_ADDR_CTRL_A 8'hb0
`define TWOC_ADDR_CTRL_B 8'hb1
`define TWOC_ADDR_COUNT 8'hb2
`define TWOC_ADDR_CMP_A 8'hb3
`define TWOC_ADDR_CMP_B 8'hb4
`define TWOC_ADDR_STATUS 8'hb5

// ****************************************************
// field positions
// ****************************************************
`define TWOC_CMP_A_HI 7
`define TWOC_CMP_A_LO 6
`define TWOC_CMP_B_HI 5
`define TWOC_CMP_B_LO 4
`define TWOC_WAVE_LOW_HI 1
`define TWOC_WAVE_LOW_LO 0
`define TWOC_WAVE_HIGH_BIT 3
`define TWOC_STAT_OVF_BIT 0
`define TWOC_STAT_DOWN_BIT 1

// ****************************************************
// write masks and reset values
// ****************************************************
`define TWOC_CTRL_A_MASK 8'hf3
`define TWOC_CTRL_B_MASK 8'h08
`define TWOC_CTRL_A_RESET 8'h00
`define TWOC_CTRL_B_RESET 8'h00
`define TWOC_CMP_RESET 8'h00

// ****************************************************
// counter limits
// ****************************************************
`define TWOC_MAX 8'hff
`define TWOC_BOTTOM 8'h00

`endif

// file: logic/twoc_pkg.sv
/*
  types of the timer waveform output control block.
  assumes: compiled before the block; constants live in the header.
*/
package twoc_pkg;

  // counting and waveform kinds decoded from the mode bits
  typedef enum logic [2:0] {
    twoc_wk_normal,
    twoc_wk_ctc,
    twoc_wk_fast,
    twoc_wk_phase,
    twoc_wk_rsvd
  } twoc_wave_t;

  // register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } twoc_bus_req_t;

  // drive of one port pin
  typedef struct packed {
    logic out;
    logic oe;
  } twoc_pin_t;

endpackage

// file: logic/twoc_top.sv
/*
  timer waveform output control: control register a, its companion
  mode bit, an 8-bit counter, two compare channels and pin muxing.
  assumes: one 100 MHz clock, synchronous active-high reset, a plain
  register port with read data one cycle after the read strobe, and
  port logic on the same clock supplying direction and port data.

*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "twoc_consts.svh"

module twoc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire twoc_pkg::twoc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic pin_dir_a,
  input wire logic pin_dir_b,
  input wire logic port_data_a,
  input wire logic port_data_b,
  output twoc_pkg::twoc_pin_t pin_a,
  output twoc_pkg::twoc_pin_t pin_b,
  output logic compare_out_a,
  output logic compare_out_b
);

  // ****************************************************
  // decode functions
  // ****************************************************

  // three mode bits to a waveform kind
  function automatic twoc_pkg::twoc_wave_t wave_kind(
    input logic [2:0] m
  );
    twoc_pkg::twoc_wave_t k;
    case (m)
      3'h0: k = twoc_pkg::twoc_wk_normal;
      3'h2: k = twoc_pkg::twoc_wk_ctc;
      3'h1, 3'h5: k = twoc_pkg::twoc_wk_phase;
      3'h3, 3'h7: k = twoc_pkg::twoc_wk_fast;
      default: k = twoc_pkg::twoc_wk_rsvd;
    endcase
    return k;
  endfunction

  // whether the compare output owns the pin
  function automatic logic pin_owned(
    input twoc_pkg::twoc_wave_t k,
    input logic [1:0] mode,
    input logic hi,
    input logic is_b
  );
    logic pwm;
    logic own;
    pwm = (k == twoc_pkg::twoc_wk_fast)
      || (k == twoc_pkg::twoc_wk_phase);
    own = (mode != 2'h0);
    // 01 in pwm: a needs high bit, b is reserved
    if (pwm && (mode == 2'h1) && (is_b || !hi))
    begin
      own = 1'b0;
    end
    return own;
  endfunction

  // next level of one compare output
  function automatic logic wave_next(
    input twoc_pkg::twoc_wave_t k,
    input logic [1:0] mode,
    input logic hi,
    input logic is_b,
    input logic hit,
    input logic at_bot,
    input logic at_top,
    input logic down,
    input logic top_eq,
    input logic cur
  );
    logic r;
    r = cur;
    case (k)
      twoc_pkg::twoc_wk_normal, twoc_pkg::twoc_wk_ctc:
      begin
        // toggle, clear or set on match
        if (hit)
        begin
          case (mode)
            2'h1: r = ~cur;
            2'h2: r = 1'b0;
            2'h3: r = 1'b1;
            default: r = cur;
          endcase
        end
      end
      twoc_pkg::twoc_wk_fast:
      begin
        if (mode[1])
        begin
          // match ignored when compare sits at top
          if (hit && !top_eq)
            r = mode[0];
          else if (at_bot)
            r = ~mode[0];
        end
        else if (mode[0] && hi && !is_b && hit)
        begin
          r = ~cur;
        end
      end
      twoc_pkg::twoc_wk_phase:
      begin
        if (mode[1])
        begin
          if (top_eq)
          begin
            // act at top instead of matching
            if (at_top)
              r = ~mode[0];
          end
          else if (hit)
          begin
            r = down ? ~mode[0] : mode[0];
          end
        end
        else if (mode[0] && hi && !is_b && hit)
        begin
          r = ~cur;
        end
      end
      default: r = cur;
    endcase
    return r;
  endfunction

  // ****************************************************
  // registers
  // ****************************************************
  logic [7:0] timer_ctrl_a; // mode fields and low mode bits
  logic [7:0] timer_ctrl_b; // holds the high mode bit
  logic [7:0] count; // counter value
  logic count_down; // phase pwm direction
  logic overflow_flag; // sticky overflow
  logic [7:0] cmp_buf [2]; // software compare values
  logic [7:0] cmp_act [2]; // values in use
  logic [1:0] wave_out; // compare outputs

  // decoded controls
  logic wave_mode_high;
  logic [1:0] wave_mode_low;
  logic [1:0] chan_mode [2];
  twoc_pkg::twoc_wave_t kind;
  logic [7:0] top;
  logic pwm;
  logic at_top;
  logic at_bot;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_status;
  logic ovf_evt;
  logic [7:0] next_count;
  logic next_down;

  assign wave_mode_high = timer_ctrl_b[`TWOC_WAVE_HIGH_BIT];
  assign wave_mode_low =
    timer_ctrl_a[`TWOC_WAVE_LOW_HI:`TWOC_WAVE_LOW_LO];
  assign chan_mode[0] = timer_ctrl_a[`TWOC_CMP_A_HI:`TWOC_CMP_A_LO];
  assign chan_mode[1] = timer_ctrl_a[`TWOC_CMP_B_HI:`TWOC_CMP_B_LO];
  // mode selects sequence and top source
  assign kind = wave_kind({wave_mode_high, wave_mode_low});
  // mode 2 and modes 4 to 7 take top from compare a
  assign top = (wave_mode_high || (wave_mode_low == 2'h2))
    ? cmp_act[0] : `TWOC_MAX;
  assign pwm = (kind == twoc_pkg::twoc_wk_fast)
    || (kind == twoc_pkg::twoc_wk_phase);
  assign at_top = (count == top);
  assign at_bot = (count == `TWOC_BOTTOM);

  // ****************************************************
  // register port decode
  // ****************************************************
  always_comb
  begin
    wr_ctrl_a = 1'b0;
    wr_ctrl_b = 1'b0;
    wr_count = 1'b0;
    wr_status = 1'b0;
    if (bus_req.addr == `TWOC_ADDR_CTRL_A)
      wr_ctrl_a = bus_req.wr;
    else if (bus_req.addr == `TWOC_ADDR_CTRL_B)
      wr_ctrl_b = bus_req.wr;
    else if (bus_req.addr == `TWOC_ADDR_COUNT)
      wr_count = bus_req.wr;
    else if (bus_req.addr == `TWOC_ADDR_STATUS)
      wr_status = bus_req.wr;
  end

  // control registers, zero after reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      timer_ctrl_a <= `TWOC_CTRL_A_RESET;
      timer_ctrl_b <= `TWOC_CTRL_B_RESET;
    end
    else
    begin
      // reserved bits 3:2 never stored
      if (wr_ctrl_a)
        timer_ctrl_a <= bus_req.wdata & `TWOC_CTRL_A_MASK;
      if (wr_ctrl_b)
        timer_ctrl_b <= bus_req.wdata & `TWOC_CTRL_B_MASK;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      bus_rdata <= 8'h00;
    else if (!bus_req.rd)
      bus_rdata <= 8'h00;
    else if (bus_req.addr == `TWOC_ADDR_CTRL_A)
      bus_rdata <= timer_ctrl_a & `TWOC_CTRL_A_MASK;
    else if (bus_req.addr == `TWOC_ADDR_CTRL_B)
      bus_rdata <= timer_ctrl_b;
    else if (bus_req.addr == `TWOC_ADDR_COUNT)
      bus_rdata <= count;
    else if (bus_req.addr == `TWOC_ADDR_CMP_A)
      bus_rdata <= cmp_buf[0];
    else if (bus_req.addr == `TWOC_ADDR_CMP_B)
      bus_rdata <= cmp_buf[1];
    else if (bus_req.addr == `TWOC_ADDR_STATUS)
      bus_rdata <= {6'h00, count_down, overflow_flag};
    else
      bus_rdata <= 8'h00; // unmapped reads zero
  end

  // ****************************************************
  // counter
  // ****************************************************

  // next count, direction and overflow event
  always_comb
  begin
    next_count = count;
    next_down = count_down;
    ovf_evt = 1'b0;
    case (kind)
      twoc_pkg::twoc_wk_phase:
      begin
        // up to top, down to bottom
        if (!count_down && at_top)
        begin
          next_down = 1'b1;
          next_count = count - 8'h01;
        end
        else if (count_down && at_bot)
        begin
          next_down = 1'b0;
          next_count = count + 8'h01;
          ovf_evt = 1'b1; // flag at bottom
        end
        else
        begin
          next_count = count_down
            ? count - 8'h01 : count + 8'h01;
        end
      end
      twoc_pkg::twoc_wk_rsvd:
      begin
        next_count = count; // reserved modes hold
        next_down = 1'b0;
      end
      default:
      begin
        // normal, clear-on-match, fast: wrap after top
        next_down = 1'b0;
        next_count = at_top ? `TWOC_BOTTOM : count + 8'h01;
        if (kind == twoc_pkg::twoc_wk_fast && wave_mode_high)
          ovf_evt = at_top; // mode 7 flags at top
        else
          ovf_evt = (count == `TWOC_MAX); // at max
      end
    endcase
  end

  // counter and direction, software write wins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      count <= 8'h00;
      count_down <= 1'b0;
    end
    else if (wr_count)
    begin
      count <= bus_req.wdata;
    end
    else
    begin
      count <= next_count;
      count_down <= next_down;
    end
  end

  // sticky overflow, write one clears, set wins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      overflow_flag <= 1'b0;
    else if (ovf_evt)
      overflow_flag <= 1'b1;
    else if (wr_status && bus_req.wdata[`TWOC_STAT_OVF_BIT])
      overflow_flag <= 1'b0;
  end

  // ****************************************************
  // compare channels
  // ****************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic wr_cmp;
      logic hit;
      logic top_eq;
      assign wr_cmp = bus_req.wr && (bus_req.addr ==
        (ch == 0 ? `TWOC_ADDR_CMP_A : `TWOC_ADDR_CMP_B));
      assign hit = (count == cmp_act[ch]);
      assign top_eq = (cmp_act[ch] == top);

      // buffered compare value
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          cmp_buf[ch] <= `TWOC_CMP_RESET;
        else if (wr_cmp)
          cmp_buf[ch] <= bus_req.wdata;
      end

      // immediate outside pwm, else at top while counting up
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          cmp_act[ch] <= `TWOC_CMP_RESET;
        else if (!pwm)
          cmp_act[ch] <= cmp_buf[ch];
        else if (at_top && !count_down)
          cmp_act[ch] <= cmp_buf[ch];
      end

      // output level; reserved b value changes nothing
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
          wave_out[ch] <= 1'b0;
        else
          wave_out[ch] <= wave_next(kind, chan_mode[ch],
            wave_mode_high, (ch == 1), hit, at_bot,
            at_top, count_down, top_eq, wave_out[ch]);
      end
    end
  endgenerate

  assign compare_out_a = wave_out[0];
  assign compare_out_b = wave_out[1];

  // ****************************************************
  // pin muxing
  // ****************************************************

  // compare output replaces port data when owned
  always_comb
  begin
    pin_a.out = pin_owned(kind, chan_mode[0], wave_mode_high, 1'b0)
      ? wave_out[0] : port_data_a;
    pin_b.out = pin_owned(kind, chan_mode[1], wave_mode_high, 1'b1)
      ? wave_out[1] : port_data_b;
    pin_a.oe = pin_dir_a; // driver needs direction set
    pin_b.oe = pin_dir_b;
  end

endmodule

// file: tb/twoc_checker.sv
/*
  port assertions of the timer waveform output control block.
  assumes: bound to twoc_top, one clock, sync active-high reset.
*/
`timescale 1ns/1ps
`include "twoc_consts.svh"
module twoc_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire twoc_pkg::twoc_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic pin_dir_a,
  input wire logic pin_dir_b,
  input wire logic port_data_a,
  input wire logic port_data_b,
  input wire twoc_pkg::twoc_pin_t pin_a,
  input wire twoc_pkg::twoc_pin_t pin_b,
  input wire logic compare_out_a,
  input wire logic compare_out_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ctl; // shadow of control a
  logic hi; // shadow of mode high bit
  logic rsv; // reserved wave mode
  logic b_rsv; // reserved b value in pwm
  logic b_own; // output b owns its pin
  logic a_own; // output a owns its pin
  assign rsv = hi & ~ctl[0];
  // pwm with mode a 01 owns the pin only when high bit set
  assign a_own = (ctl[7:6] != 2'b00)
    & ~(ctl[0] & (ctl[7:6] == 2'b01) & ~hi);
  assign b_rsv = ctl[0] & (ctl[5:4] == 2'b01);
  assign b_own = (ctl[5:4] != 2'b00) & ~b_rsv;
  // shadow control a from bus writes
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ctl <= 8'h00;
    else if (bus_req.wr && bus_req.addr == `TWOC_ADDR_CTRL_A)
      ctl <= bus_req.wdata & `TWOC_CTRL_A_MASK;
  end
  // shadow mode high bit
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      hi <= 1'b0;
    else if (bus_req.wr && bus_req.addr == `TWOC_ADDR_CTRL_B)
      hi <= bus_req.wdata[3];
  end
  // ****************************************************
  // assertions
  // ****************************************************
  property p_read_ctrl;
    bus_req.rd && bus_req.addr == 8'hb0 |=> bus_rdata == $past(ctl);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl)
    else $error("control read mismatch");
  property p_rsvd_bits;
    bus_req.rd && bus_req.addr == 8'hb0 |=> bus_rdata[3:2] == 2'b00;
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits)
    else $error("reserved control bits not zero");
  property p_unmapped;
    bus_req.rd && (bus_req.addr < 8'hb0 || bus_req.addr > 8'hb5)
      |=> bus_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_oe;
    pin_a.oe == pin_dir_a && pin_b.oe == pin_dir_b;
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable not direction bit");
  property p_mux_a;
    pin_a.out == (a_own ? compare_out_a : port_data_a);
  endproperty
  a_mux_a: assert property (p_mux_a)
    else $error("pin a source wrong");
  property p_mux_b;
    !rsv |-> pin_b.out == (b_own ? compare_out_b : port_data_b);
  endproperty
  a_mux_b: assert property (p_mux_b)
    else $error("pin b source wrong");
  property p_hold_b;
    b_rsv [*3] |-> $stable(compare_out_b);
  endproperty
  a_hold_b: assert property (p_hold_b)
    else $error("output b moved in reserved value");
  property p_rsvd_hold;
    rsv [*3] |-> $stable(compare_out_a) && $stable(compare_out_b);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold)
    else $error("output moved in reserved mode");
endmodule

bind twoc_top twoc_checker u_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .pin_dir_a(pin_dir_a),
  .pin_dir_b(pin_dir_b),
  .port_data_a(port_data_a),
  .port_data_b(port_data_b),
  .pin_a(pin_a),
  .pin_b(pin_b),
  .compare_out_a(compare_out_a),
  .compare_out_b(compare_out_b)
);

// file: tb/twoc_port_model.sv
/*
  port pin logic beside the compare outputs: direction bits and
  ordinary port data that changes every cycle.
  assumes: same clock and reset as the block.
*/
`timescale 1ns/1ps
module twoc_port_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic dir_a_req,
  input wire logic dir_b_req,
  output logic pin_dir_a = 1'b0,
  output logic pin_dir_b = 1'b0,
  output logic port_data_a = 1'b0,
  output logic port_data_b = 1'b0
);
  // direction bits as software sets them
  always @(posedge sys_clk)
  begin
    pin_dir_a <= sys_rst ? 1'b0 : dir_a_req;
    pin_dir_b <= sys_rst ? 1'b0 : dir_b_req;
  end
  // port data never sits still, so a wrong mux shows
  always @(posedge sys_clk)
  begin
    port_data_a <= ~port_data_a;
    port_data_b <= port_data_a;
  end
endmodule

// file: tb/tb.sv
/*
  testbench of the timer waveform output control block.
  assumes: checker bound by its own file, port model beside.
*/
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  twoc_pkg::twoc_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic pin_dir_a, pin_dir_b, port_data_a, port_data_b;
  twoc_pkg::twoc_pin_t pin_a, pin_b;
  logic compare_out_a, compare_out_b;
  logic dir_a_req = 1'b0; // direction requests to model
  logic dir_b_req = 1'b0;
  logic peek = 1'b0; // sample outputs at next edge
  logic rd_d = 1'b0; // read data due now
  logic [7:0] expq [$]; // expected results in order
  logic [7:0] exp_v, got_v;
  logic [31:0] seed = 32'h6bd6c2ff;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  twoc_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pin_dir_a(pin_dir_a), .pin_dir_b(pin_dir_b),
    .port_data_a(port_data_a), .port_data_b(port_data_b),
    .pin_a(pin_a), .pin_b(pin_b),
    .compare_out_a(compare_out_a), .compare_out_b(compare_out_b));
  twoc_port_model u_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .dir_a_req(dir_a_req), .dir_b_req(dir_b_req),
    .pin_dir_a(pin_dir_a), .pin_dir_b(pin_dir_b),
    .port_data_a(port_data_a), .port_data_b(port_data_b));
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    expq.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
  endtask
  task automatic look(input logic [1:0] e);
    @(posedge sys_clk);
    expq.push_back({6'h00, e});
    peek <= 1'b1;
    @(posedge sys_clk);
    peek <= 1'b0;
  endtask
  // set mode and compare b, load count, sample outputs twice
  task automatic run(input logic [7:0] ca, input logic h,
    input logic [7:0] cb, input logic [7:0] cnt, input int w1,
    input logic [1:0] e1, input int w2, input logic [1:0] e2);
    wr(8'hb4, cb);
    wr(8'hb1, {4'h0, h, 3'h0});
    wr(8'hb0, ca);
    wr(8'hb2, cnt);
    repeat (w1) @(posedge sys_clk);
    look(e1);
    repeat (w2) @(posedge sys_clk);
    look(e2);
  endtask
  // ****************************************************
  // monitor: oldest note against what appears
  // ****************************************************
  always @(posedge sys_clk)
  begin
    rd_d <= bus_req.rd;
    if (rd_d || peek)
    begin
      exp_v = expq.pop_front();
      got_v = rd_d ? bus_rdata : {6'h00, compare_out_a, compare_out_b};
      total_checks++;
      if (got_v !== exp_v)
      begin
        $display("wrong value at %0t: %h vs %h", $time, got_v, exp_v);
        fails++;
      end
    end
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'hb0, 8'h00);
    wr(8'hb0, 8'hff);
    rd(8'hb0, 8'hf3);
    rd(8'hc0, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      wr(8'hb0, seed[7:0]);
      rd(8'hb0, seed[7:0] & 8'hf3);
    end
    dir_a_req <= 1'b1;
    dir_b_req <= 1'b1;
    wr(8'hb3, 8'h80);
    run(8'hb3, 1'b0, 8'h80, 8'hf0, 40, 2'b10, 136, 2'b01);
    run(8'ha3, 1'b1, 8'h20, 8'h70, 30, 2'b11, 30, 2'b10);
    run(8'hb2, 1'b0, 8'h20, 8'h00, 40, 2'b11, 104, 2'b01);
    run(8'hb1, 1'b0, 8'h80, 8'h00, 192, 2'b01, 228, 2'b10);
    run(8'h93, 1'b0, 8'h80, 8'hf0, 40, 2'b10, 136, 2'b00);
    run(8'hf2, 1'b1, 8'h80, 8'h00, 20, 2'b00, 200, 2'b00);
    rd(8'hb0, 8'hf2);
    // phase pwm, top from compare a: a toggles, b acts at top
    run(8'h61, 1'b1, 8'h80, 8'h00, 140, 2'b11, 250, 2'b01);
    rd(8'hb5, 8'h03);
    wr(8'hb5, 8'h01);
    rd(8'hb5, 8'h02);
    repeat (120) @(posedge sys_clk);
    rd(8'hb5, 8'h01);
    repeat (2) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
